// ===== rtl/shc_pkg.sv
// Constants, types and tables for the staged heat controller.
// Assumes one 50 MHz system clock; all users refer to names by shc_pkg::.
package shc_pkg;
   // Timing
   localparam int unsigned SHC_CLK_HZ = 50_000_000;
   localparam int unsigned SHC_TICK_S = 1;
   localparam int unsigned SHC_TICK_CYC = SHC_CLK_HZ * SHC_TICK_S;
   // Register byte offsets
   localparam logic [5:0] SHC_OFS_CTRL = 6'h00;
   localparam logic [5:0] SHC_OFS_HEAT_SP1 = 6'h04;
   localparam logic [5:0] SHC_OFS_HEAT_SP2 = 6'h08;
   localparam logic [5:0] SHC_OFS_COOL_SP1 = 6'h0c;
   localparam logic [5:0] SHC_OFS_COOL_SP2 = 6'h10;
   localparam logic [5:0] SHC_OFS_PERIOD = 6'h14;
   localparam logic [5:0] SHC_OFS_GAIN = 6'h18;
   localparam logic [5:0] SHC_OFS_MAX_STEP = 6'h1c;
   localparam logic [5:0] SHC_OFS_DB_HIGH = 6'h20;
   localparam logic [5:0] SHC_OFS_DB_LOW = 6'h24;
   localparam logic [5:0] SHC_OFS_DB_RATE = 6'h28;
   localparam logic [5:0] SHC_OFS_STATUS = 6'h2c;
   localparam logic [5:0] SHC_OFS_ACTIVE_SP = 6'h30;
   // Control register fields
   localparam int SHC_CTRL_SEL_LSB = 0;
   localparam int SHC_CTRL_VAV_BIT = 2;
   localparam int SHC_CTRL_NETOCC_BIT = 3;
   localparam int SHC_CTRL_NSTG_LSB = 4;
   // Gain register fields
   localparam int SHC_GAIN_P_LSB = 0;
   localparam int SHC_GAIN_D_LSB = 8;
   localparam int SHC_GAIN_FRAC = 4;
   // Status register fields
   localparam int SHC_STAT_MODE_LSB = 0;
   localparam int SHC_STAT_STAGE_LSB = 4;
   localparam int SHC_STAT_CAP_LSB = 8;
   localparam int SHC_STAT_RELAY_LSB = 16;
   localparam int SHC_STAT_HIR_BIT = 22;
   // Reset values
   localparam logic [1:0] SHC_RST_SEL = 2'h0;
   localparam logic [3:0] SHC_RST_NSTG = 4'h9;
   localparam logic [15:0] SHC_RST_HEAT_SP = 16'h0352;
   localparam logic [15:0] SHC_RST_COOL_SP = 16'h0230;
   localparam logic [15:0] SHC_RST_PERIOD = 16'h000a;
   localparam logic [7:0] SHC_RST_P_GAIN = 8'h10;
   localparam logic [7:0] SHC_RST_D_GAIN = 8'h08;
   localparam logic [7:0] SHC_RST_MAX_STEP = 8'h0a;
   localparam logic [15:0] SHC_RST_DB_HIGH = 16'h000a;
   localparam logic [15:0] SHC_RST_DB_LOW = 16'hfff6;
   localparam logic [15:0] SHC_RST_DB_RATE = 16'h0002;
   // Capacity range in percent
   localparam logic [7:0] SHC_CAP_MAX = 8'h64;
   localparam int SHC_NSTG = 9;
   // Full-fire percent and relay pattern per stage, K1 in bit 0
   localparam logic [7:0] SHC_STG_PCT [SHC_NSTG] = '{
      8'h19, 8'h21, 8'h32, 8'h3a, 8'h43, 8'h4b, 8'h53, 8'h5c, 8'h64};
   localparam logic [5:0] SHC_STG_RLY [SHC_NSTG] = '{
      6'h01, 6'h03, 6'h05, 6'h07, 6'h0f, 6'h15, 6'h1d, 6'h1f, 6'h3f};
   // Operating modes, Gray along idle-temper-first_heat_input-second_heat_input
   typedef enum logic [1:0] {
      SHC_IDLE = 2'b00,
      SHC_TEMPER = 2'b01,
      SHC_FIRST_HEAT_INPUT = 2'b11,
      SHC_SECOND_HEAT_INPUT = 2'b10
   } shc_mode_t;
   // Calls from the base unit control
   typedef struct packed {
      logic fan;
      logic dehum;
      logic cool1;
      logic cool2;
      logic first_heat_input;
      logic second_heat_input;
   } shc_calls_t;
endpackage

// ===== rtl/shc_ctrl.sv
// Staged heat controller: mode, set point, capacity loop and relay staging.
// Assumes synchronous base unit calls and temperatures, Avalon-MM master.
// Notes on behaviour
// - Six gas relays, up to nine stages
// - Idle: no heat, all off or cooling
// - Tempering when fan/dehumidify, no cool/heat
// - Tempering holds cooling set point
// - First heat: first_heat_input only, heating set point
// - First heat energizes heat interlock relay
// - Second heat never on variable-volume units
// - Heat value in first heat, cool in tempering and second heat
// - Source 0: set points from knobs
// - Source 1: set point one values
// - Source 2: occupancy schedule picks set
// - Source 3: network schedule picks set
// - Capacity computed only in first_heat_input/tempering
// - Loop runs each period, accumulates correction
// - Error, proportional and rate terms
// - Deadband with low rate zeroes proportional
// - Correction clamped to plus/minus max step
// - New capacity is correction plus old
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module shc_ctrl #(
   parameter int unsigned TICK_CYC = shc_pkg::SHC_TICK_CYC
) (
   // Clock, reset, enable
   input wire logic CLK_SYS_I,
   input wire logic SRST_I,
   input wire logic CE_I,
   // Avalon-MM slave
   input wire logic [5:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   // Base unit and sensors
   input wire shc_pkg::shc_calls_t CALLS_I,
   input wire logic OCCUPANCY_STATE_I,
   input wire logic [15:0] SUPPLY_AIR_TEMP_I,
   input wire logic [15:0] TEMPERING_SETPOINT_KNOB_I,
   input wire logic [15:0] HEATING_SUPPLY_SETPOINT_I,
   // Relay and mode outputs
   output logic [5:0] RELAY_O,
   output logic HEAT_INTERLOCK_RELAY_O,
   output shc_pkg::shc_mode_t MODE_O
);
   logic [1:0] setpoint_source_select_reg;
   logic vav_unit_reg;
   logic net_occupied_reg;
   logic [3:0] num_stages_reg;
   logic [15:0] heat_setpoint_one_reg;
   logic [15:0] heat_setpoint_two_reg;
   logic [15:0] cool_setpoint_one_reg;
   logic [15:0] cool_setpoint_two_reg;
   logic [15:0] loop_period_seconds_reg;
   logic [7:0] p_gain_reg;
   logic [7:0] d_gain_reg;
   logic [7:0] max_step_change_reg;
   logic [15:0] deadband_high_limit_reg;
   logic [15:0] deadband_low_limit_reg;
   logic [15:0] deadband_min_rate_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;
   shc_pkg::shc_mode_t mode_reg;
   shc_pkg::shc_mode_t mode_next;
   logic [15:0] active_setpoint_reg;
   logic [15:0] active_setpoint_next;
   logic [7:0] desired_capacity_pct_reg;
   logic [7:0] desired_capacity_pct_next;
   logic signed [16:0] err_last_reg;
   logic [31:0] pre_cnt_reg;
   logic [15:0] sec_cnt_reg;
   logic [3:0] stage_reg;
   logic [3:0] stage_next;
   logic [5:0] relay_reg;
   logic [5:0] relay_next;
   logic hir_reg;
   logic req;
   logic wr_take;
   logic sec_tick;
   logic loop_run;
   logic loop_mode;
   logic use_set_one;
   logic signed [16:0] err;
   logic signed [17:0] derr;
   logic signed [25:0] p_term;
   logic signed [26:0] d_term;
   logic signed [26:0] d_abs;
   logic in_deadband;
   logic signed [27:0] pd_sum;
   logic signed [27:0] corr;
   logic signed [27:0] cap_sum;
   logic signed [27:0] step_lim;
   logic [shc_pkg::SHC_NSTG-1:0] stage_hit;

   localparam logic [31:0] PRE_LAST = 32'(TICK_CYC - 1);

   // Bus handshake: one wait cycle, then answer
   assign req = AVS_READ_I | AVS_WRITE_I;
   assign AVS_WAITREQUEST_O = req & ~(ack_reg & CE_I);
   assign wr_take = AVS_WRITE_I & ack_reg;
   assign AVS_READDATA_O = rdata_reg;

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         ack_reg <= 1'b0;
      end else if (CE_I) begin
         ack_reg <= req & ~ack_reg;
      end
   end

   // Register writes
   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         setpoint_source_select_reg <= shc_pkg::SHC_RST_SEL;
         vav_unit_reg <= 1'b0;
         net_occupied_reg <= 1'b0;
         num_stages_reg <= shc_pkg::SHC_RST_NSTG;
         heat_setpoint_one_reg <= shc_pkg::SHC_RST_HEAT_SP;
         heat_setpoint_two_reg <= shc_pkg::SHC_RST_HEAT_SP;
         cool_setpoint_one_reg <= shc_pkg::SHC_RST_COOL_SP;
         cool_setpoint_two_reg <= shc_pkg::SHC_RST_COOL_SP;
         loop_period_seconds_reg <= shc_pkg::SHC_RST_PERIOD;
         p_gain_reg <= shc_pkg::SHC_RST_P_GAIN;
         d_gain_reg <= shc_pkg::SHC_RST_D_GAIN;
         max_step_change_reg <= shc_pkg::SHC_RST_MAX_STEP;
         deadband_high_limit_reg <= shc_pkg::SHC_RST_DB_HIGH;
         deadband_low_limit_reg <= shc_pkg::SHC_RST_DB_LOW;
         deadband_min_rate_reg <= shc_pkg::SHC_RST_DB_RATE;
      end else if (CE_I && wr_take) begin
         unique case (AVS_ADDRESS_I)
            shc_pkg::SHC_OFS_CTRL: begin
               setpoint_source_select_reg <=
                  AVS_WRITEDATA_I[shc_pkg::SHC_CTRL_SEL_LSB +: 2];
               vav_unit_reg <= AVS_WRITEDATA_I[shc_pkg::SHC_CTRL_VAV_BIT];
               net_occupied_reg <= AVS_WRITEDATA_I[shc_pkg::SHC_CTRL_NETOCC_BIT];
               num_stages_reg <= AVS_WRITEDATA_I[shc_pkg::SHC_CTRL_NSTG_LSB +: 4];
            end
            shc_pkg::SHC_OFS_HEAT_SP1: heat_setpoint_one_reg <= AVS_WRITEDATA_I[15:0];
            shc_pkg::SHC_OFS_HEAT_SP2: heat_setpoint_two_reg <= AVS_WRITEDATA_I[15:0];
            shc_pkg::SHC_OFS_COOL_SP1: cool_setpoint_one_reg <= AVS_WRITEDATA_I[15:0];
            shc_pkg::SHC_OFS_COOL_SP2: cool_setpoint_two_reg <= AVS_WRITEDATA_I[15:0];
            shc_pkg::SHC_OFS_PERIOD: loop_period_seconds_reg <= AVS_WRITEDATA_I[15:0];
            shc_pkg::SHC_OFS_GAIN: begin
               p_gain_reg <= AVS_WRITEDATA_I[shc_pkg::SHC_GAIN_P_LSB +: 8];
               d_gain_reg <= AVS_WRITEDATA_I[shc_pkg::SHC_GAIN_D_LSB +: 8];
            end
            shc_pkg::SHC_OFS_MAX_STEP: max_step_change_reg <= AVS_WRITEDATA_I[7:0];
            shc_pkg::SHC_OFS_DB_HIGH: deadband_high_limit_reg <= AVS_WRITEDATA_I[15:0];
            shc_pkg::SHC_OFS_DB_LOW: deadband_low_limit_reg <= AVS_WRITEDATA_I[15:0];
            shc_pkg::SHC_OFS_DB_RATE: deadband_min_rate_reg <= AVS_WRITEDATA_I[15:0];
            default: begin
            end
         endcase
      end
   end

   // Read data captured in the wait cycle
   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         rdata_reg <= 32'h0000_0000;
      end else if (CE_I && AVS_READ_I && !ack_reg) begin
         rdata_reg <= 32'h0000_0000;
         unique case (AVS_ADDRESS_I)
            shc_pkg::SHC_OFS_CTRL: rdata_reg <= {24'h00_0000, num_stages_reg,
               net_occupied_reg, vav_unit_reg, setpoint_source_select_reg};
            shc_pkg::SHC_OFS_HEAT_SP1: rdata_reg <= {16'h0000, heat_setpoint_one_reg};
            shc_pkg::SHC_OFS_HEAT_SP2: rdata_reg <= {16'h0000, heat_setpoint_two_reg};
            shc_pkg::SHC_OFS_COOL_SP1: rdata_reg <= {16'h0000, cool_setpoint_one_reg};
            shc_pkg::SHC_OFS_COOL_SP2: rdata_reg <= {16'h0000, cool_setpoint_two_reg};
            shc_pkg::SHC_OFS_PERIOD: rdata_reg <= {16'h0000, loop_period_seconds_reg};
            shc_pkg::SHC_OFS_GAIN: rdata_reg <= {16'h0000, d_gain_reg, p_gain_reg};
            shc_pkg::SHC_OFS_MAX_STEP: rdata_reg <= {24'h00_0000, max_step_change_reg};
            shc_pkg::SHC_OFS_DB_HIGH: rdata_reg <= {16'h0000, deadband_high_limit_reg};
            shc_pkg::SHC_OFS_DB_LOW: rdata_reg <= {16'h0000, deadband_low_limit_reg};
            shc_pkg::SHC_OFS_DB_RATE: rdata_reg <= {16'h0000, deadband_min_rate_reg};
            shc_pkg::SHC_OFS_STATUS: rdata_reg <= {9'h000, hir_reg, relay_reg,
               desired_capacity_pct_reg, stage_reg, 2'h0, mode_reg};
            shc_pkg::SHC_OFS_ACTIVE_SP: rdata_reg <= {16'h0000, active_setpoint_reg};
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // Mode selection from base unit calls
   always_comb begin
      mode_next = shc_pkg::SHC_IDLE;
      if (CALLS_I.cool1 || CALLS_I.cool2) begin
         mode_next = shc_pkg::SHC_IDLE;
      end else if (CALLS_I.first_heat_input && !CALLS_I.second_heat_input) begin
         mode_next = shc_pkg::SHC_FIRST_HEAT_INPUT;
      end else if (CALLS_I.second_heat_input) begin
         mode_next = vav_unit_reg ? shc_pkg::SHC_IDLE : shc_pkg::SHC_SECOND_HEAT_INPUT;
      end else if (CALLS_I.fan || CALLS_I.dehum) begin
         mode_next = shc_pkg::SHC_TEMPER;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         mode_reg <= shc_pkg::SHC_IDLE;
      end else if (CE_I) begin
         mode_reg <= mode_next;
      end
   end

   // Set point source selection
   always_comb begin
      use_set_one = 1'b1;
      unique case (setpoint_source_select_reg)
         2'h1: use_set_one = 1'b1;
         2'h2: use_set_one = OCCUPANCY_STATE_I;
         2'h3: use_set_one = net_occupied_reg;
         default: use_set_one = 1'b1;
      endcase
      if (mode_reg == shc_pkg::SHC_FIRST_HEAT_INPUT) begin
         if (setpoint_source_select_reg == 2'h0) begin
            active_setpoint_next = HEATING_SUPPLY_SETPOINT_I;
         end else begin
            active_setpoint_next = use_set_one ? heat_setpoint_one_reg : heat_setpoint_two_reg;
         end
      end else if (setpoint_source_select_reg == 2'h0) begin
         active_setpoint_next = TEMPERING_SETPOINT_KNOB_I;
      end else begin
         active_setpoint_next = use_set_one ? cool_setpoint_one_reg : cool_setpoint_two_reg;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         active_setpoint_reg <= shc_pkg::SHC_RST_COOL_SP;
      end else if (CE_I) begin
         active_setpoint_reg <= active_setpoint_next;
      end
   end

   // Loop period timer
   // loop only in first_heat_input or tempering
   assign loop_mode = (mode_reg == shc_pkg::SHC_FIRST_HEAT_INPUT) || (mode_reg == shc_pkg::SHC_TEMPER);
   assign sec_tick = (pre_cnt_reg == PRE_LAST);
   assign loop_run = loop_mode && sec_tick && ((sec_cnt_reg + 16'h0001) >= loop_period_seconds_reg);

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         pre_cnt_reg <= 32'h0000_0000;
         sec_cnt_reg <= 16'h0000;
      end else if (CE_I) begin
         if (!loop_mode) begin
            pre_cnt_reg <= 32'h0000_0000;
            sec_cnt_reg <= 16'h0000;
         end else if (sec_tick) begin
            pre_cnt_reg <= 32'h0000_0000;
            sec_cnt_reg <= loop_run ? 16'h0000 : sec_cnt_reg + 16'h0001;
         end else begin
            pre_cnt_reg <= pre_cnt_reg + 32'h0000_0001;
         end
      end
   end

   // Capacity arithmetic
   always_comb begin
      err = $signed({active_setpoint_reg[15], active_setpoint_reg}) -
            $signed({SUPPLY_AIR_TEMP_I[15], SUPPLY_AIR_TEMP_I});
      derr = $signed({err[16], err}) - $signed({err_last_reg[16], err_last_reg});
      p_term = (err * $signed({1'b0, p_gain_reg})) >>> shc_pkg::SHC_GAIN_FRAC;
      d_term = (derr * $signed({1'b0, d_gain_reg})) >>> shc_pkg::SHC_GAIN_FRAC;
      d_abs = d_term[26] ? -d_term : d_term;
      in_deadband = (err < $signed({deadband_high_limit_reg[15], deadband_high_limit_reg})) &&
                    (err > $signed({deadband_low_limit_reg[15], deadband_low_limit_reg})) &&
                    (d_abs < $signed({11'h000, deadband_min_rate_reg}));
      pd_sum = (in_deadband ? 28'sh000_0000 : 28'($signed(p_term))) + 28'(d_term);
      step_lim = $signed({20'h0_0000, max_step_change_reg});
      if (pd_sum > step_lim) begin
         corr = step_lim;
      end else if (pd_sum < -step_lim) begin
         corr = -step_lim;
      end else begin
         corr = pd_sum;
      end
      cap_sum = corr + $signed({20'h0_0000, desired_capacity_pct_reg});
      if (cap_sum < 28'sh000_0000) begin
         desired_capacity_pct_next = 8'h00;
      end else if (cap_sum > $signed({20'h0_0000, shc_pkg::SHC_CAP_MAX})) begin
         desired_capacity_pct_next = shc_pkg::SHC_CAP_MAX;
      end else begin
         desired_capacity_pct_next = cap_sum[7:0];
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         desired_capacity_pct_reg <= 8'h00;
         err_last_reg <= 17'sh0_0000;
      end else if (CE_I) begin
         if (!loop_mode) begin
            desired_capacity_pct_reg <= 8'h00;
            err_last_reg <= 17'sh0_0000;
         end else if (loop_run) begin
            desired_capacity_pct_reg <= desired_capacity_pct_next;
            err_last_reg <= err;
         end
      end
   end

   // Stage thresholds per entry
   genvar gi;
   generate
      for (gi = 0; gi < shc_pkg::SHC_NSTG; gi++) begin : g_stage
         assign stage_hit[gi] = (desired_capacity_pct_reg >= shc_pkg::SHC_STG_PCT[gi]) &&
                                (4'(gi) < num_stages_reg);
      end
   endgenerate

   always_comb begin
      stage_next = 4'h0;
      relay_next = 6'h00;
      for (int i = 0; i < shc_pkg::SHC_NSTG; i++) begin
         if (stage_hit[i]) begin
            stage_next = 4'(i + 1);
            relay_next = shc_pkg::SHC_STG_RLY[i];
         end
      end
      // Full fire in second heat
      if (mode_reg == shc_pkg::SHC_SECOND_HEAT_INPUT) begin
         for (int i = 0; i < shc_pkg::SHC_NSTG; i++) begin
            if (4'(i) < num_stages_reg) begin
               stage_next = 4'(i + 1);
               relay_next = shc_pkg::SHC_STG_RLY[i];
            end
         end
      end
      if (mode_reg == shc_pkg::SHC_IDLE) begin
         stage_next = 4'h0;
         relay_next = 6'h00;
      end
   end

   // Relay outputs
   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         stage_reg <= 4'h0;
         relay_reg <= 6'h00;
         hir_reg <= 1'b0;
      end else if (CE_I) begin
         stage_reg <= stage_next;
         relay_reg <= relay_next;
         hir_reg <= (mode_reg == shc_pkg::SHC_FIRST_HEAT_INPUT);
      end
   end

   assign RELAY_O = relay_reg;
   assign HEAT_INTERLOCK_RELAY_O = hir_reg;
   assign MODE_O = mode_reg;
endmodule
`default_nettype wire

// ===== sim/shc_ctrl_props.sv
// Port checker for the staged heat controller.
// Assumes a bind onto shc_ctrl and calls that change only while CE_I is high.
`timescale 1ns/100ps
`default_nettype none
module shc_ctrl_props #(
   parameter int unsigned TICK_CYC = 10
) (
   // Clock and control
   input wire logic CLK_SYS_I,
   input wire logic SRST_I,
   input wire logic CE_I,
   // Bus
   input wire logic [5:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_READDATA_O,
   input wire logic AVS_WAITREQUEST_O,
   // Unit side
   input wire shc_pkg::shc_calls_t CALLS_I,
   input wire logic [5:0] RELAY_O,
   input wire logic HEAT_INTERLOCK_RELAY_O,
   input wire shc_pkg::shc_mode_t MODE_O
);
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (SRST_I);
   sequence s_req;
      CE_I && (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
   endsequence
   sequence s_idle3;
      (MODE_O == shc_pkg::SHC_IDLE) [*3];
   endsequence
   a_idle_relays_off: assert property (s_idle3 |-> RELAY_O == 6'h00)
      else $error("relays on in idle");
   a_cool_forces_idle: assert property (CE_I && (CALLS_I.cool1 || CALLS_I.cool2) |=> MODE_O == shc_pkg::SHC_IDLE)
      else $error("cooling call not idle");
   a_first_heat_input_entry: assert property (CE_I && CALLS_I.first_heat_input && !CALLS_I.second_heat_input
      && !CALLS_I.cool1 && !CALLS_I.cool2 |=> MODE_O == shc_pkg::SHC_FIRST_HEAT_INPUT) else $error("first heat not entered");
   a_temper_entry: assert property (CE_I && (CALLS_I.fan || CALLS_I.dehum) && !CALLS_I.cool1 && !CALLS_I.cool2
      && !CALLS_I.first_heat_input && !CALLS_I.second_heat_input |=> MODE_O == shc_pkg::SHC_TEMPER)
      else $error("tempering not entered");
   a_second_heat_input_limit: assert property (CE_I && CALLS_I.second_heat_input |=> MODE_O inside {shc_pkg::SHC_IDLE, shc_pkg::SHC_SECOND_HEAT_INPUT})
      else $error("bad mode on second heat call");
   a_interlock_follows: assert property ($past(CE_I) |-> HEAT_INTERLOCK_RELAY_O == ($past(MODE_O) == shc_pkg::SHC_FIRST_HEAT_INPUT))
      else $error("interlock does not follow first heat");
   a_relay_pattern: assert property (RELAY_O inside {6'h00, 6'h01, 6'h03, 6'h05, 6'h07, 6'h0f, 6'h15, 6'h1d, 6'h1f, 6'h3f})
      else $error("relay pattern outside stage table");
   a_bus_one_wait: assert property (s_req ##1 CE_I |-> !AVS_WAITREQUEST_O)
      else $error("no answer after one wait state");
   a_unmapped_zero: assert property (AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I > 6'h30 |-> AVS_READDATA_O == 32'h0)
      else $error("unmapped read not zero");
   a_reset_quiet: assert property (disable iff (1'b0) SRST_I && CE_I |=> RELAY_O == 6'h00 && !HEAT_INTERLOCK_RELAY_O)
      else $error("outputs active after reset");
endmodule
bind shc_ctrl shc_ctrl_props #(.TICK_CYC(TICK_CYC)) i_shc_ctrl_props (
   .CLK_SYS_I(CLK_SYS_I), .SRST_I(SRST_I), .CE_I(CE_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
   .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O),
   .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .CALLS_I(CALLS_I), .RELAY_O(RELAY_O),
   .HEAT_INTERLOCK_RELAY_O(HEAT_INTERLOCK_RELAY_O), .MODE_O(MODE_O)
);
`default_nettype wire

// ===== sim/shc_unit_model.sv
// Base unit control and supply-air sensor model.
// Assumes the bench requests calls and temperature at rising edges.
`timescale 1ns/100ps
`default_nettype none
module shc_unit_model #(
   parameter logic [15:0] HEAT_KNOB = 16'h012c,
   parameter logic [15:0] TEMPER_KNOB = 16'h0028
) (
   // Clock
   input wire logic clk_i,
   // Requests
   input wire shc_pkg::shc_calls_t calls_want_i,
   input wire logic [15:0] sat_want_i,
   // Unit side
   output var shc_pkg::shc_calls_t calls_o,
   output var logic [15:0] sat_o,
   output logic [15:0] temper_knob_o,
   output logic [15:0] heat_knob_o
);
   assign temper_knob_o = TEMPER_KNOB;
   assign heat_knob_o = HEAT_KNOB;
   initial begin
      calls_o = '0;
      sat_o = '0;
   end
   always @(posedge clk_i) begin
      calls_o <= calls_want_i;
      sat_o <= sat_want_i;
   end
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the staged heat controller.
// Assumes a short tick and the unit model on the unit-side inputs.
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam logic [15:0] HK = 16'h012c;
   localparam logic [15:0] TK = 16'h0028;
   localparam logic [5:0] RA [8] = '{6'h00, 6'h04, 6'h0c, 6'h14, 6'h18, 6'h1c, 6'h24, 6'h38};
   localparam logic [31:0] RV [8] = '{32'h90, 32'h352, 32'h230, 32'ha, 32'h0810, 32'ha, 32'hfff6, 32'h0};
   localparam logic [5:0] CORNER [5] = '{6'h02, 6'h20, 6'h10, 6'h01, 6'h0a};
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic [5:0] addr = '0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = '0;
   logic [31:0] rdata, q;
   logic waitreq, heat_interlock_relay, occupancy_state = 1'b0;
   shc_pkg::shc_calls_t calls_want = '0;
   shc_pkg::shc_calls_t calls;
   logic [15:0] sat_want = '0;
   logic [15:0] supply_air_temp, tknob, hknob;
   logic [5:0] relay;
   shc_pkg::shc_mode_t mode;
   int n_mismatch = 0;
   int n_tests = 0;
   always #10 clk = ~clk;
   shc_unit_model #(.HEAT_KNOB(HK), .TEMPER_KNOB(TK)) i_shc_unit_model (.clk_i(clk), .calls_want_i(calls_want),
      .sat_want_i(sat_want), .calls_o(calls), .sat_o(supply_air_temp), .temper_knob_o(tknob), .heat_knob_o(hknob));
   shc_ctrl #(.TICK_CYC(10)) i_shc_ctrl (.CLK_SYS_I(clk), .SRST_I(srst), .CE_I(ce), .AVS_ADDRESS_I(addr),
      .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
      .AVS_WAITREQUEST_O(waitreq), .CALLS_I(calls), .OCCUPANCY_STATE_I(occupancy_state), .SUPPLY_AIR_TEMP_I(supply_air_temp),
      .TEMPERING_SETPOINT_KNOB_I(tknob), .HEATING_SUPPLY_SETPOINT_I(hknob), .RELAY_O(relay),
      .HEAT_INTERLOCK_RELAY_O(heat_interlock_relay), .MODE_O(mode));
   task automatic results();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      wr <= we;
      rd <= !we;
      addr <= a;
      wdata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 50);
      if (waitreq !== 1'b0) n_mismatch++;
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   // Polls capacity, each change must be one clamped step
   task automatic ramp(input int step, input logic [7:0] stop);
      logic [7:0] last;
      int n, e;
      n = 0;
      bus(1'b0, shc_pkg::SHC_OFS_STATUS, '0);
      last = q[15:8];
      while (last !== stop && n < 400) begin
         bus(1'b0, shc_pkg::SHC_OFS_STATUS, '0);
         n++;
         if (q[15:8] !== last) begin
            e = int'(last) + step;
            e = (e > 100) ? 100 : ((e < 0) ? 0 : e);
            chk("cap step", q[15:8], 32'(e));
            last = q[15:8];
         end
      end
      chk("cap end", 32'(last), 32'(stop));
   endtask
   function automatic shc_pkg::shc_mode_t exp_mode(input shc_pkg::shc_calls_t c, input logic vav);
      if (c.cool1 || c.cool2) return shc_pkg::SHC_IDLE;
      if (c.first_heat_input && !c.second_heat_input) return shc_pkg::SHC_FIRST_HEAT_INPUT;
      if (c.second_heat_input) return vav ? shc_pkg::SHC_IDLE : shc_pkg::SHC_SECOND_HEAT_INPUT;
      return (c.fan || c.dehum) ? shc_pkg::SHC_TEMPER : shc_pkg::SHC_IDLE;
   endfunction
   function automatic logic [15:0] exp_sp(input int s);
      logic one;
      one = (s[3:2] == 1) || (s[3:2] == 2 && !s[1]) || (s[3:2] == 3 && s[1]);
      if (s[3:2] == 0) return s[0] ? HK : TK;
      return s[0] ? (one ? 16'h0064 : 16'h00c8) : (one ? 16'h0032 : 16'h003c);
   endfunction
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      results();
   end
   initial begin
      void'($urandom(32'h5bf9));
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, RA[i], '0);
         chk("reset reg", q, RV[i]);
      end
      bus(1'b1, shc_pkg::SHC_OFS_STATUS, 32'hffffffff);
      bus(1'b0, shc_pkg::SHC_OFS_STATUS, '0);
      chk("status ro", q, 32'h0);
      bus(1'b1, shc_pkg::SHC_OFS_CTRL, 32'h91);
      for (int i = 0; i < 40; i++) begin
         if (i == 20) bus(1'b1, shc_pkg::SHC_OFS_CTRL, 32'h95);
         calls_want <= (i % 20 < 5) ? CORNER[i % 20] : 6'($urandom);
         repeat (4) @(posedge clk);
         chk("mode", 32'(mode), 32'(exp_mode(calls_want, i >= 20)));
         chk("interlock", 32'(heat_interlock_relay), 32'(exp_mode(calls_want, i >= 20) == shc_pkg::SHC_FIRST_HEAT_INPUT));
      end
      ce <= 1'b0;
      q = 32'(mode);
      calls_want <= (mode == shc_pkg::SHC_FIRST_HEAT_INPUT) ? 6'h20 : 6'h02;
      repeat (4) @(posedge clk);
      chk("ce hold", 32'(mode), q);
      ce <= 1'b1;
      repeat (3) @(posedge clk);
      chk("ce resume", 32'(mode), 32'(exp_mode(calls_want, 1'b1)));
      bus(1'b1, shc_pkg::SHC_OFS_HEAT_SP1, 32'h64);
      bus(1'b1, shc_pkg::SHC_OFS_HEAT_SP2, 32'hc8);
      bus(1'b1, shc_pkg::SHC_OFS_COOL_SP1, 32'h32);
      bus(1'b1, shc_pkg::SHC_OFS_COOL_SP2, 32'h3c);
      for (int s = 0; s < 16; s++) begin
         bus(1'b1, shc_pkg::SHC_OFS_CTRL, {24'h0, 4'h9, s[1], 1'b0, s[3:2]});
         occupancy_state <= !s[1];
         calls_want <= s[0] ? 6'h02 : 6'h20;
         repeat (4) @(posedge clk);
         bus(1'b0, shc_pkg::SHC_OFS_ACTIVE_SP, '0);
         chk("active sp", q, {16'h0, exp_sp(s)});
      end
      bus(1'b1, shc_pkg::SHC_OFS_CTRL, 32'h91);
      calls_want <= 6'h01;
      repeat (6) @(posedge clk);
      chk("full fire", relay, 6'h3f);
      bus(1'b1, shc_pkg::SHC_OFS_PERIOD, 32'h1);
      bus(1'b1, shc_pkg::SHC_OFS_GAIN, 32'h10);
      calls_want <= 6'h00;
      sat_want <= 16'h0032;
      repeat (6) @(posedge clk);
      calls_want <= 6'h02;
      ramp(10, 8'h1e);
      sat_want <= 16'h005f;
      repeat (60) @(posedge clk);
      bus(1'b0, shc_pkg::SHC_OFS_STATUS, '0);
      chk("deadband hold", q[15:8], 8'h1e);
      chk("stage one", relay, 6'h01);
      sat_want <= 16'h0096;
      ramp(-10, 8'h00);
      bus(1'b1, shc_pkg::SHC_OFS_DB_HIGH, 32'h2);
      bus(1'b1, shc_pkg::SHC_OFS_DB_LOW, 32'hfffe);
      sat_want <= 16'h0061;
      ramp(3, 8'h64);
      repeat (3) @(posedge clk);
      chk("top stage", relay, 6'h3f);
      calls_want <= 6'h00;
      repeat (6) @(posedge clk);
      chk("idle relays", relay, 6'h00);
      bus(1'b0, shc_pkg::SHC_OFS_STATUS, '0);
      chk("idle cap", q[15:8], 8'h00);
      bus(1'b1, shc_pkg::SHC_OFS_GAIN, 32'h1000);
      sat_want <= 16'h0000;
      calls_want <= 6'h20;
      repeat (80) @(posedge clk);
      bus(1'b0, shc_pkg::SHC_OFS_STATUS, '0);
      chk("rate term", q[15:8], 8'h0a);
      results();
   end
endmodule
`default_nettype wire
